// ==== common/sram_ctrl_pkg.sv ====
// Constants shared by the asynchronous static memory controller.
// Assumes a 20 MHz system clock and a 128K x 8 asynchronous memory outside.
// Function
// - Controller holds write data stable across the edge that ends the write.
// - Controller holds the write strobe high throughout every read cycle.
// - Address-controlled read keeps device selected, output strobe low, new data per address; not used here, address held steady while selected.
// - Select-controlled read presents valid address before or with select activation.
// - Controller never drives data lines while the memory drives them.
// - Controller drives each chip select to a defined logic level always.
package sram_ctrl_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 50;
  // Read cycle, write pulse and data setup in ns
  localparam int READ_CYCLE_NS = 45;
  localparam int WRITE_PULSE_NS = 35;
  localparam int DATA_SETUP_NS = 25;
  localparam int READ_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_CYC);
  localparam logic [CNT_W-1:0] WRITE_CNT = CNT_W'(WRITE_CYC);
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
endpackage

// ==== core/sram_pin_sync.sv ====
// Two-flip-flop synchroniser for the memory data pins.
// Assumes the pins are asynchronous to CLK.
`timescale 1ns/1ps
module sram_pin_sync #(
  parameter int W = 8
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] synced
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = raw;
    sync_d = meta_q;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign synced = sync_q;
endmodule // sram_pin_sync

// ==== core/sram_ctrl.sv ====
// Host controller that drives a 128K x 8 asynchronous static memory by its pins.
// Assumes one request at a time on a valid/ready port and a memory obeying its truth table.
`timescale 1ns/1ps
module sram_ctrl
  import sram_ctrl_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [DATA_W-1:0] RD_DATA,
  output logic [ADDR_W-1:0] MEM_ADDRESS_BIT,
  output logic MEM_SELECT_LOW_ACTIVE_B,
  output logic MEM_SELECT_HIGH_ACTIVE,
  output logic MEM_WRITE_B,
  output logic MEM_OUTPUT_B,
  input wire logic [DATA_W-1:0] MEM_DATA_PORT_BIT_I,
  output logic [DATA_W-1:0] MEM_DATA_PORT_BIT_O,
  output logic MEM_DATA_PORT_BIT_OE
);
  typedef enum logic [2:0] {
    IDLE,
    RD_SETUP,
    RD_WAIT,
    RD_DONE,
    WR_SETUP,
    WR_PULSE,
    WR_HOLD
  } st_t;

  st_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic sel_b_q, sel_b_d;
  logic sel_h_q, sel_h_d;
  logic we_b_q, we_b_d;
  logic oe_b_q, oe_b_d;
  logic doe_q, doe_d;
  logic rdy_q, rdy_d;
  logic rv_q, rv_d;
  logic [DATA_W-1:0] din_s;

  sram_pin_sync #(.W(DATA_W)) u_sync (
    .CLK(CLK),
    .RST_B(RST_B),
    .raw(MEM_DATA_PORT_BIT_I),
    .synced(din_s)
  );

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    sel_b_d = 1'b1;
    sel_h_d = 1'b0;
    we_b_d = 1'b1;
    oe_b_d = 1'b1;
    doe_d = 1'b0;
    rdy_d = 1'b0;
    rv_d = 1'b0;
    unique case (st_q)
      IDLE: begin
        rdy_d = 1'b1;
        if (REQ_VALID && rdy_q) begin
          rdy_d = 1'b0;
          // Address is latched and driven one cycle ahead of select
          addr_d = REQ_ADDR;
          wdat_d = REQ_WDATA;
          st_d = REQ_WRITE ? WR_SETUP : RD_SETUP;
        end
      end
      RD_SETUP: begin
        sel_b_d = 1'b0;
        sel_h_d = 1'b1;
        oe_b_d = 1'b0;
        cnt_d = READ_CNT;
        st_d = RD_WAIT;
      end
      RD_WAIT: begin
        sel_b_d = 1'b0;
        sel_h_d = 1'b1;
        oe_b_d = 1'b0;
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          st_d = RD_DONE;
        end
      end
      RD_DONE: begin
        // Synchronised pins now show the byte read
        rdat_d = din_s;
        rv_d = 1'b1;
        st_d = IDLE;
      end
      WR_SETUP: begin
        sel_b_d = 1'b0;
        sel_h_d = 1'b1;
        we_b_d = 1'b0;
        doe_d = 1'b1;
        cnt_d = WRITE_CNT;
        st_d = WR_PULSE;
      end
      WR_PULSE: begin
        sel_b_d = 1'b0;
        sel_h_d = 1'b1;
        we_b_d = 1'b0;
        doe_d = 1'b1;
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          // Write strobe rises first and ends the write; select stays
          we_b_d = 1'b1;
          st_d = WR_HOLD;
        end
      end
      WR_HOLD: begin
        // Data held one cycle past the terminating strobe edge
        doe_d = 1'b0;
        st_d = IDLE;
      end
      default: st_d = IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= IDLE;
      cnt_q <= '0;
      addr_q <= ADDR_RST;
      wdat_q <= DATA_RST;
      rdat_q <= DATA_RST;
      sel_b_q <= 1'b1;
      sel_h_q <= 1'b0;
      we_b_q <= 1'b1;
      oe_b_q <= 1'b1;
      doe_q <= 1'b0;
      rdy_q <= 1'b0;
      rv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      sel_b_q <= sel_b_d;
      sel_h_q <= sel_h_d;
      we_b_q <= we_b_d;
      oe_b_q <= oe_b_d;
      doe_q <= doe_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
    end
  end

  assign REQ_READY = rdy_q;
  assign RD_VALID = rv_q;
  assign RD_DATA = rdat_q;
  assign MEM_ADDRESS_BIT = addr_q;
  assign MEM_SELECT_LOW_ACTIVE_B = sel_b_q;
  assign MEM_SELECT_HIGH_ACTIVE = sel_h_q;
  assign MEM_WRITE_B = we_b_q;
  assign MEM_OUTPUT_B = oe_b_q;
  assign MEM_DATA_PORT_BIT_O = wdat_q;
  assign MEM_DATA_PORT_BIT_OE = doe_q;

  // Pin protocol checks on the registered memory controls
  chk_read_we_high: assert property (@(posedge CLK) disable iff (!RST_B)
    !oe_b_q |-> we_b_q)
    else $error("write strobe low during read");
  chk_no_contention: assert property (@(posedge CLK) disable iff (!RST_B)
    !oe_b_q |-> !doe_q)
    else $error("data driven while output strobe low");
  chk_select_defined: assert property (@(posedge CLK) disable iff (!RST_B)
    sel_b_q == !sel_h_q)
    else $error("selects disagree");
  chk_addr_before_sel: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(sel_b_q) |-> $stable(addr_q))
    else $error("address moved with select");
  chk_write_data_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(we_b_q) |-> doe_q && $stable(wdat_q) && !sel_b_q)
    else $error("data not held");
  chk_write_width: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(we_b_q) |-> !we_b_q [*1] ##1 we_b_q)
    else $error("write pulse width wrong");
  chk_write_sel: assert property (@(posedge CLK) disable iff (!RST_B)
    !we_b_q |-> !sel_b_q && sel_h_q && doe_q)
    else $error("write without select");
  chk_read_len: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(oe_b_q) |-> !oe_b_q [*3] ##1 oe_b_q)
    else $error("read length wrong");
  chk_read_sel_held: assert property (@(posedge CLK) disable iff (!RST_B)
    !oe_b_q |-> !sel_b_q && sel_h_q)
    else $error("select dropped during read");
  chk_write_release: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(we_b_q) |=> sel_b_q && !doe_q)
    else $error("select or data not released after write");
  chk_drive_after_read: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(doe_q) |-> oe_b_q && $past(oe_b_q))
    else $error("data driven next to output strobe");
  chk_addr_steady: assert property (@(posedge CLK) disable iff (!RST_B)
    !sel_b_q |-> $stable(addr_q))
    else $error("address moved while selected");
  chk_idle_pins: assert property (@(posedge CLK) disable iff (!RST_B)
    rdy_q |-> sel_b_q && !sel_h_q && we_b_q && oe_b_q && !doe_q)
    else $error("pins not idle while ready");
  chk_read_we_idle: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(oe_b_q) |-> we_b_q && $past(we_b_q))
    else $error("read started next to write strobe");
  chk_read_capture: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(oe_b_q) |-> rv_q && sel_b_q)
    else $error("read ended without capture");

  cov_read: cover property (@(posedge CLK) disable iff (!RST_B) rv_q);
  cov_write: cover property (@(posedge CLK) disable iff (!RST_B) $rose(we_b_q));
  cov_b2b: cover property (@(posedge CLK) disable iff (!RST_B) rv_q ##3 $fell(we_b_q));
  cov_read_pair: cover property (@(posedge CLK) disable iff (!RST_B) rv_q ##6 rv_q);
endmodule // sram_ctrl

// ==== verif/sram_model.sv ====
// Behavioural 128K x 8 asynchronous static memory on the controller's pins.
// Assumes the bench resolves the shared data wire from the controller's output enable alone.
`timescale 1ns/1ps
module sram_model
  import sram_ctrl_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr,
  input wire logic sel_b,
  input wire logic sel,
  input wire logic we_b,
  input wire logic oe_b,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout,
  output logic drive
);
  logic [DATA_W-1:0] mem [0:131071];
  logic [DATA_W-1:0] last = 8'h00;
  wire act = !sel_b && sel;
  wire wr = act && !we_b;
  assign drive = act && we_b && !oe_b;
  // Released wire shows the inverse of the last driven byte
  assign dout = drive ? mem[addr] : ~last;
  always @(negedge wr) mem[addr] = din;
  always @(dout) if (drive) last = dout;
endmodule // sram_model

// ==== verif/sram_ctrl_tb.sv ====
// Self-checking bench for the memory controller with a behavioural memory.
// Assumes the package constants and a 20 MHz clock.
`timescale 1ns/1ps
module sram_ctrl_tb;
  import sram_ctrl_pkg::*;
  logic CLK = 0, RST_B = 0, REQ_VALID = 0, REQ_WRITE = 0;
  logic [ADDR_W-1:0] REQ_ADDR = '0;
  logic [DATA_W-1:0] REQ_WDATA = '0;
  logic REQ_READY, RD_VALID, sb, s, wb, ob, oe, drv;
  logic [DATA_W-1:0] RD_DATA, dout, mdout, bus;
  logic [ADDR_W-1:0] ma;
  logic [DATA_W-1:0] ref_mem [int];
  logic [ADDR_W-1:0] addrs [24];
  logic [31:0] seed = 32'hD6A034F4;
  int failures = 0, total_checks = 0;
  assign bus = oe ? dout : mdout;
  sram_ctrl sram_ctrl_i (.CLK(CLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
    .REQ_READY(REQ_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
    .MEM_ADDRESS_BIT(ma), .MEM_SELECT_LOW_ACTIVE_B(sb), .MEM_SELECT_HIGH_ACTIVE(s),
    .MEM_WRITE_B(wb), .MEM_OUTPUT_B(ob), .MEM_DATA_PORT_BIT_I(bus),
    .MEM_DATA_PORT_BIT_O(dout), .MEM_DATA_PORT_BIT_OE(oe));
  sram_model sram_model_i (.addr(ma), .sel_b(sb), .sel(s), .we_b(wb), .oe_b(ob),
    .din(bus), .dout(mdout), .drive(drv));
  initial forever #25 CLK = ~CLK;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge CLK);
    REQ_VALID = 1'b1;
    REQ_WRITE = w;
    REQ_ADDR = a;
    REQ_WDATA = d;
    // Ready is looked at on the falling edge, where it has settled
    while (REQ_READY !== 1'b1 && n < 50) begin
      @(negedge CLK);
      n++;
    end
    if (n == 50) begin
      failures++;
      $display("CHECK FAILED %0t request never taken", $time);
    end
    @(posedge CLK);
    @(negedge CLK);
    REQ_VALID = 1'b0;
    if (w) ref_mem[a] = d;
    else begin
      n = 0;
      while (RD_VALID !== 1'b1 && n < 20) begin
        @(negedge CLK);
        n++;
      end
      chk({7'h00, RD_VALID}, 8'h01);
      chk(RD_DATA, ref_mem[a]);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Pin watch: no contention, write strobe idle while outputs enabled
  always @(negedge CLK) begin
    if (RST_B && ((oe && drv) || (!wb && !ob))) begin
      failures++;
      $display("CHECK FAILED %0t pin conflict", $time);
    end
  end
  initial begin
    #2000000;
    failures++;
    results();
  end
  initial begin
    repeat (10) @(posedge CLK);
    @(negedge CLK);
    RST_B = 1'b1;
    xfer(1'b1, 17'h00000, 8'h5A);
    xfer(1'b1, 17'h1FFFF, 8'hA5);
    xfer(1'b1, 17'h00000, 8'hC3);
    xfer(1'b0, 17'h00000, 8'h00);
    xfer(1'b0, 17'h1FFFF, 8'h00);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      addrs[i] = seed[ADDR_W-1:0];
      xfer(1'b1, seed[ADDR_W-1:0], seed[31:24]);
    end
    // Reset in mid-run once idle; the memory keeps its contents
    while (REQ_READY !== 1'b1) @(negedge CLK);
    RST_B = 1'b0;
    @(negedge CLK);
    chk({sb, s, wb, ob, oe, REQ_READY, RD_VALID, 1'b0}, 8'hB0);
    repeat (2) @(negedge CLK);
    RST_B = 1'b1;
    @(negedge CLK);
    chk({sb, s, wb, ob, oe, REQ_READY, RD_VALID, 1'b0}, 8'hB4);
    for (int i = 0; i < 24; i++) xfer(1'b0, addrs[i], 8'h00);
    results();
  end
endmodule // sram_ctrl_tb
